// ==== hw/sie_device.sv ====
// Purpose: SIE status and MCU FIFO access control, device end of the link
// Assumes: MCU port reads answer one cycle after the read strobe
// Notes:   FIFO data paths live outside; this block only steers and flags
// Functional notes
// - Auto mode: adopt address after IN data acked
// - Manual mode: address changes on holding write
// - Firmware clears auto mode after next SETUP
// - Shared FIFO access error flag, firmware clears
// - OUT flag: nonzero OUT sets, firmware/SETUP clear
// - Read-only bit: current token is IN
// - Read-only bit: NAK was transmitted
// - CRC/PID/incomplete token sets failure flag
// - Active-low token-in-progress flag, resets high
// - NAK interrupt unless mask bit set
// - USB bus reset clears FIFO access control
// - Firmware selects FIFO, raises then drops request
// - MCU write: direction 1, back to 0 ends
// - MCU read: direction 0, set 1 when done
// - Clear empties FIFO; next IN gets under-run
// - Separate iso IN and OUT interrupt enables
// - Setup flag holds until next packet enters
// - Read-only ready bit of selected FIFO
// - Zero-length flag set by host, cleared on read
// - Three-bit endpoint select, codes 0 to 4
// - Iso endpoints 2 and 3 not firmware accessible
// - Address holding: 7-bit address, wake enable, zero
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sie_device (
	// Clock and reset
	input  wire logic       mclk_in,
	input  wire logic       arst_n_in,
	// Link to host end
	usb_link_if.dev_mp      lnk,
	// MCU register port
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic [7:0]      rdata_out,
	// FIFO side status
	input  wire logic [4:0] fifo_ready_in,
	input  wire logic       iso_in_event_in,
	input  wire logic       iso_out_event_in,
	// FIFO side control
	output logic            fifo_grant_out,
	output logic [2:0]      fifo_ep_out,
	output logic            fifo_write_out,
	output logic            fifo_commit_out,
	output logic            fifo_read_done_out,
	output logic            fifo_clear_out,
	// Device status
	output logic [6:0]      dev_addr_out,
	output logic            wake_en_out,
	output logic            irq_out
);
	import sie_pkg::*;
	typedef struct packed {
		logic       auto_address_update;
		logic       in_tok;
		logic       nak;
		logic       tok_n;
		logic       nak_mask;
		logic       req;
		logic       tx;
		logic       iso_in_en;
		logic       iso_out_en;
		logic       setup_f;
		logic       zlen;
		logic [2:0] ep_sel;
		logic [7:0] ahr;
		logic [6:0] dev_addr;
		logic [4:0] underrun;
		logic       hs_valid;
		hs_t        hs_code;
		logic       irq;
		logic [7:0] rdata;
		logic       grant;
		logic       commit;
		logic       rd_done;
		logic       clr_pulse;
	} dev_state_t;
	dev_state_t q, d;
	logic       err_set, err_clr, err_f;
	logic       out_set, out_clr, out_f;
	logic       chk_set, chk_clr, chk_f;
	logic       wr_status, wr_fifo;
	// Only endpoints 0, 1 and 4 may be claimed by firmware
	function automatic logic mcu_ep_ok(input logic [2:0] ep);
		return (ep <= EP_LAST) && (ep != EP_ISO_A) && (ep != EP_ISO_B);
	endfunction : mcu_ep_ok
	function automatic logic ep_ready(input logic [2:0] ep, input logic [4:0] rdy);
		return (ep <= EP_LAST) ? rdy[ep] : 1'b0;
	endfunction : ep_ready
	assign wr_status = wr_in && (addr_in == OFS_SIE_STATUS);
	assign wr_fifo   = wr_in && (addr_in == OFS_FIFO_CTRL);
	// Hardware-set flags; software clears by writing zero
	assign err_set = wr_fifo && wdata_in[FC_REQUEST] && !q.req
		&& !mcu_ep_ok(q.ep_sel);
	assign err_clr = wr_status && !wdata_in[ST_ERR];
	assign out_set = lnk.tok_valid && (lnk.tok_addr == q.dev_addr)
		&& (lnk.tok_pid == PID_OUT) && !lnk.tok_zero;
	assign out_clr = (wr_status && !wdata_in[ST_OUT]) || (lnk.tok_valid
		&& (lnk.tok_addr == q.dev_addr) && (lnk.tok_pid == PID_SETUP));
	assign chk_set = lnk.tok_err;
	assign chk_clr = wr_status && !wdata_in[ST_CHECK];
	sticky_flag u_err (
		.mclk_in   (mclk_in),
		.arst_n_in (arst_n_in),
		.set_in    (err_set),
		.clr_in    (err_clr),
		.flag_out  (err_f)
	);
	sticky_flag u_out (
		.mclk_in   (mclk_in),
		.arst_n_in (arst_n_in),
		.set_in    (out_set),
		.clr_in    (out_clr),
		.flag_out  (out_f)
	);
	sticky_flag u_chk (
		.mclk_in   (mclk_in),
		.arst_n_in (arst_n_in),
		.set_in    (chk_set),
		.clr_in    (chk_clr),
		.flag_out  (chk_f)
	);
	always_comb begin
		d = q;
		d.hs_valid  = 1'b0;
		d.hs_code   = HS_NONE;
		d.commit    = 1'b0;
		d.rd_done   = 1'b0;
		d.clr_pulse = 1'b0;
		d.rdata     = 8'h00;
		d.tok_n     = !lnk.tok_busy;
		// MCU writes; read-only bits are simply not stored
		if (wr_in) begin
			case (addr_in)
				OFS_EP_SELECT: d.ep_sel = wdata_in[2:0];
				OFS_ADDR_HOLD: begin
					d.ahr = wdata_in;
					if (!q.auto_address_update) begin
						d.dev_addr = wdata_in[7:AH_ADDR_LO];
					end
				end
				OFS_SIE_STATUS: begin
					d.auto_address_update     = wdata_in[ST_AUTO_ADDR];
					d.nak_mask = wdata_in[ST_NAK_MASK];
				end
				OFS_FIFO_CTRL: begin
					d.req        = wdata_in[FC_REQUEST];
					d.tx         = wdata_in[FC_TX];
					d.iso_in_en  = wdata_in[FC_ISO_IN];
					d.iso_out_en = wdata_in[FC_ISO_OUT];
					d.setup_f    = wdata_in[FC_SETUP];
					// Write end: direction drops while request still held
					if (q.req && q.tx && wdata_in[FC_REQUEST] && !wdata_in[FC_TX]) begin
						d.commit = 1'b1;
					end
					// Read end: direction rises while request still held
					if (q.req && !q.tx && wdata_in[FC_REQUEST] && wdata_in[FC_TX]) begin
						d.rd_done = 1'b1;
						d.zlen    = 1'b0;
					end
					// Clear acts even when the FIFO is not ready
					if (wdata_in[FC_CLEAR] && mcu_ep_ok(q.ep_sel)) begin
						d.clr_pulse          = 1'b1;
						d.underrun[q.ep_sel] = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// Token handling for our address
		if (lnk.tok_valid && (lnk.tok_addr == q.dev_addr)) begin
			d.hs_valid = 1'b1;
			d.in_tok   = (lnk.tok_pid == PID_IN);
			case (lnk.tok_pid)
				PID_SETUP: begin
					d.hs_code = HS_ACK;
					d.setup_f = 1'b1;
				end
				PID_IN: begin
					if (lnk.tok_ep <= EP_LAST && q.underrun[lnk.tok_ep]) begin
						d.hs_code               = HS_UNDERRUN;
						d.underrun[lnk.tok_ep] = 1'b0;
					end else if (ep_ready(lnk.tok_ep, fifo_ready_in)) begin
						d.hs_code = HS_ACK;
					end else begin
						d.hs_code = HS_NAK;
					end
				end
				PID_OUT: begin
					d.hs_code = ep_ready(lnk.tok_ep, fifo_ready_in) ? HS_ACK : HS_NAK;
					if (lnk.tok_zero) begin
						d.zlen = 1'b1;
					end else begin
						d.setup_f = 1'b0;
					end
				end
				default: d.hs_code = HS_NONE;
			endcase
			d.nak = (d.hs_code == HS_NAK);
		end

		// Deferred address takes effect once the host acks IN data
		if (q.auto_address_update && lnk.in_ack) begin
			d.dev_addr = q.ahr[7:AH_ADDR_LO];
		end

		// Bus reset wins over a FIFO control write in the same cycle
		if (lnk.bus_reset) begin
			d.req        = 1'b0;
			d.tx         = 1'b0;
			d.iso_in_en  = 1'b0;
			d.iso_out_en = 1'b0;
			d.setup_f    = 1'b0;
			d.zlen       = 1'b0;
			d.underrun   = '0;
			d.commit     = 1'b0;
			d.rd_done    = 1'b0;
			d.clr_pulse  = 1'b0;
		end

		d.grant = d.req && mcu_ep_ok(d.ep_sel);
		d.irq = (d.hs_valid && d.hs_code == HS_NAK && !q.nak_mask)
			|| (iso_in_event_in && q.iso_in_en)
			|| (iso_out_event_in && q.iso_out_en);

		// Read data stand only in the cycle after the strobe
		if (rd_in) begin
			case (addr_in)
				OFS_EP_SELECT:  d.rdata = {5'h00, q.ep_sel};
				OFS_ADDR_HOLD:  d.rdata = q.ahr;
				OFS_SIE_STATUS: d.rdata = {q.nak_mask, q.tok_n, chk_f, q.nak, q.in_tok,
					out_f, err_f, q.auto_address_update};
				OFS_FIFO_CTRL:  d.rdata = {q.zlen,
					mcu_ep_ok(q.ep_sel) && ep_ready(q.ep_sel, fifo_ready_in),
					q.setup_f, q.iso_out_en, q.iso_in_en, 1'b0, q.tx, q.req};
				default:        d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q          <= '0;
			q.tok_n    <= SIE_STATUS_RST[ST_TOKEN_N];
			q.ahr      <= ADDR_HOLD_RST;
			q.ep_sel   <= EP_SELECT_RST;
			q.hs_code  <= HS_NONE;
		end else begin
			q <= d;
		end
	end
	assign lnk.hs_valid       = q.hs_valid;
	assign lnk.hs_code        = q.hs_code;
	assign rdata_out          = q.rdata;
	assign fifo_grant_out     = q.grant;
	assign fifo_ep_out        = q.ep_sel;
	assign fifo_write_out     = q.tx;
	assign fifo_commit_out    = q.commit;
	assign fifo_read_done_out = q.rd_done;
	assign fifo_clear_out     = q.clr_pulse;
	assign dev_addr_out       = q.dev_addr;
	assign wake_en_out        = q.ahr[AH_WAKE];
	assign irq_out            = q.irq;
endmodule : sie_device
`default_nettype wire

// ==== pkg/sie_pkg.sv ====
// Purpose: Shared constants and types for the SIE status/FIFO access ends
// Assumes: 250 MHz system clock, full-speed link abstracted to token events
// Notes:   Register offsets are byte addresses on the MCU register port
package sie_pkg;
	// Register offsets
	localparam logic [7:0] OFS_EP_SELECT  = 8'h22;
	localparam logic [7:0] OFS_ADDR_HOLD  = 8'h23;
	localparam logic [7:0] OFS_SIE_STATUS = 8'h25;
	localparam logic [7:0] OFS_FIFO_CTRL  = 8'h26;
	// sie_status fields
	localparam int ST_AUTO_ADDR = 0;
	localparam int ST_ERR       = 1;
	localparam int ST_OUT       = 2;
	localparam int ST_IN        = 3;
	localparam int ST_NAK       = 4;
	localparam int ST_CHECK     = 5;
	localparam int ST_TOKEN_N   = 6;
	localparam int ST_NAK_MASK  = 7;
	// fifo_access_control fields
	localparam int FC_REQUEST = 0;
	localparam int FC_TX      = 1;
	localparam int FC_CLEAR   = 2;
	localparam int FC_ISO_IN  = 3;
	localparam int FC_ISO_OUT = 4;
	localparam int FC_SETUP   = 5;
	localparam int FC_READY   = 6;
	localparam int FC_ZLEN    = 7;
	// address_holding_reg fields
	localparam int AH_WAKE    = 0;
	localparam int AH_ADDR_LO = 1;
	// Reset values
	localparam logic [7:0] SIE_STATUS_RST = 8'h40;
	localparam logic [7:0] FIFO_CTRL_RST  = 8'h00;
	localparam logic [7:0] ADDR_HOLD_RST  = 8'h00;
	localparam logic [2:0] EP_SELECT_RST  = 3'h0;
	// Endpoint codes
	localparam logic [2:0] EP_LAST  = 3'h4;
	localparam logic [2:0] EP_ISO_A = 3'h2;
	localparam logic [2:0] EP_ISO_B = 3'h3;
	// Timing
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int BIT_TIME_PS     = 83333;
	localparam int TOKEN_BITS      = 32;
	localparam int TURNAROUND_BITS = 18;
	localparam int TOKEN_CYC   = (TOKEN_BITS * BIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TIMEOUT_CYC = (TURNAROUND_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
	localparam int CNT_W       = 10;

	typedef enum logic [1:0] {PID_SETUP, PID_IN, PID_OUT} pid_t;
	typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_UNDERRUN, HS_NONE} hs_t;
endpackage : sie_pkg

// ==== pkg/usb_link_if.sv ====
// Purpose: Token-level link between the host end and the SIE device end
// Assumes: Both ends clocked by the same mclk_in
// Notes:   Pulses last one cycle; tok_busy and bus_reset are levels
`timescale 1ns/10ps
`default_nettype none
interface usb_link_if;
	import sie_pkg::*;
	logic       tok_busy;
	logic       tok_valid;
	logic       tok_err;
	pid_t       tok_pid;
	logic [2:0] tok_ep;
	logic [6:0] tok_addr;
	logic       tok_zero;
	logic       in_ack;
	logic       bus_reset;
	logic       hs_valid;
	hs_t        hs_code;

	modport dev_mp (
		input  tok_busy, tok_valid, tok_err, tok_pid, tok_ep, tok_addr, tok_zero,
		input  in_ack, bus_reset,
		output hs_valid, hs_code
	);
	modport host_mp (
		output tok_busy, tok_valid, tok_err, tok_pid, tok_ep, tok_addr, tok_zero,
		output in_ack, bus_reset,
		input  hs_valid, hs_code
	);
endinterface : usb_link_if
`default_nettype wire

// ==== hw/sticky_flag.sv ====
// Purpose: Hardware-set, software-cleared status bit
// Assumes: set and clear are synchronous one-cycle terms
// Notes:   Set wins so an event in the clearing cycle is kept
`timescale 1ns/10ps
`default_nettype none
module sticky_flag (
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic arst_n_in,
	// Control
	input  wire logic set_in,
	input  wire logic clr_in,
	// Status
	output logic      flag_out
);
	typedef struct packed {
		logic flag;
	} flag_state_t;

	flag_state_t q, d;

	always_comb begin
		d = q;
		if (clr_in) begin
			d.flag = 1'b0;
		end
		if (set_in) begin
			d.flag = 1'b1;
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign flag_out = q.flag;
endmodule : sticky_flag
`default_nettype wire

// ==== hw/usb_host_end.sv ====
// Purpose: Host end of the token link: sends tokens, collects handshakes
// Assumes: One transaction outstanding at a time
// Notes:   Token length and turnaround follow full-speed bit time
`timescale 1ns/10ps
`default_nettype none
module usb_host_end (
	// Clock and reset
	input  wire logic              mclk_in,
	input  wire logic              arst_n_in,
	// Link to device end
	usb_link_if.host_mp            lnk,
	// Command side
	input  wire logic              cmd_valid_in,
	input  wire sie_pkg::pid_t     cmd_pid_in,
	input  wire logic [2:0]        cmd_ep_in,
	input  wire logic [6:0]        cmd_addr_in,
	input  wire logic              cmd_zero_in,
	input  wire logic              cmd_corrupt_in,
	input  wire logic              bus_reset_in,
	output logic                   cmd_ready_out,
	// Answer side
	output logic                   resp_valid_out,
	output sie_pkg::hs_t           resp_code_out,
	output logic                   resp_timeout_out
);
	import sie_pkg::*;

	typedef enum {H_IDLE, H_TOKEN, H_WAIT} host_st_t;

	typedef struct packed {
		host_st_t         st;
		logic [CNT_W-1:0] cnt;
		pid_t             pid;
		logic [2:0]       ep;
		logic [6:0]       addr;
		logic             zero;
		logic             corrupt;
		logic             busy;
		logic             tok_valid;
		logic             tok_err;
		logic             in_ack;
		logic             bus_reset;
		logic             ready;
		logic             resp_valid;
		hs_t              resp_code;
		logic             timeout;
	} host_state_t;

	host_state_t q, d;

	always_comb begin
		d = q;
		d.tok_valid  = 1'b0;
		d.tok_err    = 1'b0;
		d.in_ack     = 1'b0;
		d.resp_valid = 1'b0;
		d.timeout    = 1'b0;
		d.bus_reset  = bus_reset_in;
		case (q.st)
			H_IDLE: begin
				if (cmd_valid_in && q.ready && !bus_reset_in) begin
					d.st      = H_TOKEN;
					d.pid     = cmd_pid_in;
					d.ep      = cmd_ep_in;
					d.addr    = cmd_addr_in;
					d.zero    = cmd_zero_in;
					d.corrupt = cmd_corrupt_in;
					d.cnt     = CNT_W'(TOKEN_CYC - 1);
					d.busy    = 1'b1;
					d.ready   = 1'b0;
				end
			end
			H_TOKEN: begin
				if (q.cnt == '0) begin
					d.busy = 1'b0;
					// A damaged token draws no handshake
					if (q.corrupt) begin
						d.tok_err = 1'b1;
						d.st      = H_IDLE;
						d.ready   = 1'b1;
					end else begin
						d.tok_valid = 1'b1;
						d.st        = H_WAIT;
						d.cnt       = CNT_W'(TIMEOUT_CYC - 1);
					end
				end else begin
					d.cnt = q.cnt - CNT_W'(1);
				end
			end
			H_WAIT: begin
				if (lnk.hs_valid) begin
					d.resp_valid = 1'b1;
					d.resp_code  = lnk.hs_code;
					// Acking IN data lets a deferred address take effect
					d.in_ack = (q.pid == PID_IN) && (lnk.hs_code == HS_ACK);
					d.st     = H_IDLE;
					d.ready  = 1'b1;
				end else if (q.cnt == '0) begin
					d.timeout = 1'b1;
					d.st      = H_IDLE;
					d.ready   = 1'b1;
				end else begin
					d.cnt = q.cnt - CNT_W'(1);
				end
			end
			default: begin
				d.st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q           <= '0;
			q.st        <= H_IDLE;
			q.ready     <= 1'b1;
			q.pid       <= PID_SETUP;
			q.resp_code <= HS_NONE;
		end else begin
			q <= d;
		end
	end

	assign lnk.tok_busy  = q.busy;
	assign lnk.tok_valid = q.tok_valid;
	assign lnk.tok_err   = q.tok_err;
	assign lnk.tok_pid   = q.pid;
	assign lnk.tok_ep    = q.ep;
	assign lnk.tok_addr  = q.addr;
	assign lnk.tok_zero  = q.zero;
	assign lnk.in_ack    = q.in_ack;
	assign lnk.bus_reset = q.bus_reset;
	assign cmd_ready_out    = q.ready;
	assign resp_valid_out   = q.resp_valid;
	assign resp_code_out    = q.resp_code;
	assign resp_timeout_out = q.timeout;
endmodule : usb_host_end
`default_nettype wire

// ==== verif/sie_link_assertions.sv ====
// Purpose: Link-level checks between the host end and the SIE device end
// Assumes: One clock, reset active low
// Notes:   Sees only the link signals, so address matching is not judged here
`timescale 1ns/10ps
`default_nettype none
module sie_link_assertions (
	// Clock and reset
	input wire logic          mclk_in,
	input wire logic          arst_n_in,
	// Host to device
	input wire logic          tok_busy,
	input wire logic          tok_valid,
	input wire logic          tok_err,
	input wire sie_pkg::pid_t tok_pid,
	input wire logic [2:0]    tok_ep,
	input wire logic [6:0]    tok_addr,
	input wire logic          tok_zero,
	input wire logic          in_ack,
	input wire logic          bus_reset,
	// Device to host
	input wire logic          hs_valid,
	input wire sie_pkg::hs_t  hs_code
);
	import sie_pkg::*;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	a_hs_has_cause: assert property (hs_valid |-> $past(tok_valid))
		else $error("handshake without a token");
	a_hs_one_cycle: assert property (hs_valid |=> !hs_valid)
		else $error("handshake longer than one cycle");
	a_bad_tok_silent: assert property (tok_err |=> !hs_valid)
		else $error("handshake after a damaged token");
	a_tok_good_or_bad: assert property (tok_valid |-> !tok_busy && !tok_err)
		else $error("token both good and damaged or still busy");
	a_busy_end_marked: assert property ($fell(tok_busy) |-> tok_valid || tok_err)
		else $error("token ended without a verdict");
	a_busy_min_len: assert property ($rose(tok_busy) |-> tok_busy [*8])
		else $error("token shorter than eight cycles");
	a_setup_acked: assert property
		((tok_valid && tok_pid == PID_SETUP) |=> (!hs_valid || hs_code == HS_ACK))
		else $error("setup token not acknowledged");
	a_out_no_underrun: assert property
		((tok_valid && tok_pid == PID_OUT) |=> (!hs_valid || hs_code != HS_UNDERRUN))
		else $error("under-run given to an OUT token");
	a_ack_before_inack: assert property
		(in_ack |-> $past(hs_valid) && $past(hs_code) == HS_ACK)
		else $error("IN acknowledge without device ACK");

	c_nak_sent: cover property (hs_valid && hs_code == HS_NAK);
	c_underrun: cover property (hs_valid && hs_code == HS_UNDERRUN);
	c_bad_token: cover property (tok_err);
	c_in_acked: cover property (in_ack);
endmodule : sie_link_assertions
`default_nettype wire

// ==== verif/usb_sie_status_fifo_access_bench.sv ====
// Purpose: Self-checking bench for host end and SIE device end together
// Assumes: 250 MHz clock, register reads answer one cycle after the strobe
// Notes:   Each token costs some 670 cycles, so scenarios share transfers
`timescale 1ns/10ps
`default_nettype none
module usb_sie_status_fifo_access_bench;
	import sie_pkg::*;
	logic       mclk_in    = 1'b0;
	logic       arst_n_in  = 1'b0;
	logic [7:0] addr       = 8'h00;
	logic [7:0] wdata      = 8'h00;
	logic       wr         = 1'b0;
	logic       rd         = 1'b0;
	logic       iso_in     = 1'b0;
	logic       iso_out    = 1'b0;
	logic       bus_rst    = 1'b0;
	logic [4:0] fifo_ready = 5'h03;
	logic       cmd_valid  = 1'b0;
	pid_t       cmd_pid    = PID_SETUP;
	logic [2:0] cmd_ep     = 3'h0;
	logic [6:0] cur        = 7'h00;
	logic       cmd_zero   = 1'b0;
	logic       cmd_bad    = 1'b0;
	logic [7:0] rdata;
	logic [6:0] dev_addr;
	logic       grant, commit, rdone, fclr, wake, irq, ready, rv, rto, fwr;
	logic [2:0] fep;
	hs_t        rcode;
	int         miscompares = 0;
	int         n_compared  = 0;
	int         cyc = 0;
	int         n_irq = 0;
	int         n_commit = 0;
	int         n_rdone = 0;
	int         n_clr = 0;

	usb_link_if lnk ();
	sie_device u_sie_device (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .lnk(lnk.dev_mp),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.fifo_ready_in(fifo_ready), .iso_in_event_in(iso_in), .iso_out_event_in(iso_out),
		.fifo_grant_out(grant), .fifo_ep_out(fep), .fifo_write_out(fwr),
		.fifo_commit_out(commit),
		.fifo_read_done_out(rdone), .fifo_clear_out(fclr), .dev_addr_out(dev_addr),
		.wake_en_out(wake), .irq_out(irq));
	usb_host_end u_usb_host_end (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .lnk(lnk.host_mp),
		.cmd_valid_in(cmd_valid), .cmd_pid_in(cmd_pid), .cmd_ep_in(cmd_ep), .cmd_addr_in(cur),
		.cmd_zero_in(cmd_zero), .cmd_corrupt_in(cmd_bad), .bus_reset_in(bus_rst),
		.cmd_ready_out(ready), .resp_valid_out(rv), .resp_code_out(rcode),
		.resp_timeout_out(rto));
	sie_link_assertions u_chk (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.tok_busy(lnk.tok_busy), .tok_valid(lnk.tok_valid), .tok_err(lnk.tok_err),
		.tok_pid(lnk.tok_pid), .tok_ep(lnk.tok_ep), .tok_addr(lnk.tok_addr),
		.tok_zero(lnk.tok_zero), .in_ack(lnk.in_ack), .bus_reset(lnk.bus_reset),
		.hs_valid(lnk.hs_valid), .hs_code(lnk.hs_code));

	initial forever #2 mclk_in = ~mclk_in;

	task automatic results();
		if (miscompares == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	// Event pulses are counted so that checks need not hit the exact cycle
	always @(posedge mclk_in) begin
		cyc++;
		if (irq === 1'b1) n_irq++;
		if (commit === 1'b1) n_commit++;
		if (rdone === 1'b1) n_rdone++;
		if (fclr === 1'b1) n_clr++;
		if (cyc == 20000) begin
			miscompares++;
			results();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask : wreg

	task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge mclk_in);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		@(posedge mclk_in);
		chk(rdata & m, e);
	endtask : rchk

	// Waits for the answer, the host timeout, or the host going idle
	task automatic xfer(input pid_t p, input logic [2:0] ep, input logic z, input logic bad,
			input logic eg, input hs_t ec);
		logic g;
		hs_t  c;
		g = 1'b0;
		c = HS_NONE;
		@(posedge mclk_in);
		cmd_valid <= 1'b1;
		cmd_pid   <= p;
		cmd_ep    <= ep;
		cmd_zero  <= z;
		cmd_bad   <= bad;
		@(posedge mclk_in);
		cmd_valid <= 1'b0;
		for (int i = 0; i < 1200; i++) begin
			@(posedge mclk_in);
			if (rv === 1'b1) begin
				g = 1'b1;
				c = rcode;
			end
			if (rv === 1'b1 || rto === 1'b1 || (ready === 1'b1 && i > 4)) break;
		end
		repeat (3) @(posedge mclk_in);
		chk({5'h0, g, c}, {5'h0, eg, ec});
	endtask : xfer

	task automatic iso_pulse();
		@(posedge mclk_in);
		iso_in  <= 1'b1;
		iso_out <= 1'b1;
		@(posedge mclk_in);
		iso_in  <= 1'b0;
		iso_out <= 1'b0;
		repeat (3) @(posedge mclk_in);
	endtask : iso_pulse

	initial begin
		repeat (16) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		rchk(OFS_SIE_STATUS, 8'hff, 8'h40);
		rchk(OFS_FIFO_CTRL, 8'hff, 8'h40);
		rchk(OFS_ADDR_HOLD, 8'hff, 8'h00);
		rchk(8'h30, 8'hff, 8'h00);
		wreg(OFS_SIE_STATUS, 8'hfe);
		rchk(OFS_SIE_STATUS, 8'hff, 8'hc0);
		wreg(OFS_SIE_STATUS, 8'h00);
		wreg(OFS_ADDR_HOLD, 8'h0b);
		repeat (2) @(posedge mclk_in);
		chk({wake, dev_addr}, 8'h85);
		cur <= 7'h05;
		xfer(PID_SETUP, 3'h0, 1'b0, 1'b0, 1'b1, HS_ACK);
		rchk(OFS_FIFO_CTRL, 8'hff, 8'h60);
		xfer(PID_OUT, 3'h1, 1'b0, 1'b0, 1'b1, HS_ACK);
		rchk(OFS_SIE_STATUS, 8'hff, 8'h44);
		rchk(OFS_FIFO_CTRL, 8'hff, 8'h40);
		xfer(PID_SETUP, 3'h0, 1'b0, 1'b0, 1'b1, HS_ACK);
		rchk(OFS_SIE_STATUS, 8'hff, 8'h40);
		xfer(PID_OUT, 3'h1, 1'b1, 1'b0, 1'b1, HS_ACK);
		rchk(OFS_FIFO_CTRL, 8'hff, 8'he0);
		wreg(OFS_EP_SELECT, 8'h01);
		wreg(OFS_FIFO_CTRL, 8'h01);
		wreg(OFS_FIFO_CTRL, 8'h03);
		rchk(OFS_FIFO_CTRL, 8'hff, 8'h43);
		chk(n_rdone[7:0], 8'h01);
		chk({7'h0, fwr}, 8'h01);
		wreg(OFS_FIFO_CTRL, 8'h00);
		wreg(OFS_FIFO_CTRL, 8'h03);
		wreg(OFS_FIFO_CTRL, 8'h01);
		wreg(OFS_FIFO_CTRL, 8'h00);
		chk(n_commit[7:0], 8'h01);
		for (int e = 0; e < 8; e++) begin
			wreg(OFS_EP_SELECT, e[7:0]);
			rchk(OFS_EP_SELECT, 8'hff, e[7:0]);
			wreg(OFS_FIFO_CTRL, 8'h01);
			repeat (2) @(posedge mclk_in);
			chk({7'h0, grant}, {7'h0, (e < 5 && e != 2 && e != 3)});
			chk({5'h0, fep}, e[7:0]);
			rchk(OFS_SIE_STATUS, 8'h02, {6'h0, (e > 4 || e == 2 || e == 3), 1'b0});
			wreg(OFS_FIFO_CTRL, 8'h00);
			wreg(OFS_SIE_STATUS, 8'h00);
		end
		wreg(OFS_EP_SELECT, 8'h01);
		wreg(OFS_FIFO_CTRL, 8'h04);
		rchk(OFS_FIFO_CTRL, 8'h04, 8'h00);
		chk(n_clr[7:0], 8'h01);
		xfer(PID_IN, 3'h1, 1'b0, 1'b0, 1'b1, HS_UNDERRUN);
		xfer(PID_IN, 3'h1, 1'b0, 1'b0, 1'b1, HS_ACK);
		rchk(OFS_SIE_STATUS, 8'hff, 8'h48);
		xfer(PID_IN, 3'h4, 1'b0, 1'b0, 1'b1, HS_NAK);
		rchk(OFS_SIE_STATUS, 8'hff, 8'h58);
		chk(n_irq[7:0], 8'h01);
		wreg(OFS_SIE_STATUS, 8'h80);
		xfer(PID_IN, 3'h4, 1'b0, 1'b0, 1'b1, HS_NAK);
		chk(n_irq[7:0], 8'h01);
		wreg(OFS_SIE_STATUS, 8'h00);
		wreg(OFS_FIFO_CTRL, 8'h08);
		iso_pulse();
		chk(n_irq[7:0], 8'h02);
		wreg(OFS_FIFO_CTRL, 8'h10);
		iso_pulse();
		chk(n_irq[7:0], 8'h03);
		xfer(PID_OUT, 3'h1, 1'b0, 1'b1, 1'b0, HS_NONE);
		rchk(OFS_SIE_STATUS, 8'h20, 8'h20);
		wreg(OFS_SIE_STATUS, 8'h00);
		rchk(OFS_SIE_STATUS, 8'h20, 8'h00);
		wreg(OFS_FIFO_CTRL, 8'h18);
		@(posedge mclk_in);
		bus_rst <= 1'b1;
		repeat (4) @(posedge mclk_in);
		bus_rst <= 1'b0;
		rchk(OFS_FIFO_CTRL, 8'hbf, 8'h00);
		wreg(OFS_SIE_STATUS, 8'h01);
		wreg(OFS_ADDR_HOLD, 8'h0e);
		repeat (2) @(posedge mclk_in);
		chk({1'b0, dev_addr}, 8'h05);
		xfer(PID_IN, 3'h1, 1'b0, 1'b0, 1'b1, HS_ACK);
		chk({1'b0, dev_addr}, 8'h07);
		xfer(PID_IN, 3'h1, 1'b0, 1'b0, 1'b0, HS_NONE);
		cur <= 7'h07;
		xfer(PID_SETUP, 3'h0, 1'b0, 1'b0, 1'b1, HS_ACK);
		wreg(OFS_SIE_STATUS, 8'h00);
		wreg(OFS_ADDR_HOLD, 8'h12);
		repeat (2) @(posedge mclk_in);
		chk({1'b0, dev_addr}, 8'h09);
		results();
	end
endmodule : usb_sie_status_fifo_access_bench
`default_nettype wire
